// File: src/sample_cycle_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - Trigger event on interval or flow quantity
// - Time pacing: trigger when timer reaches interval
// - Flow pacing: trigger when pulse total equals target
// - First move distributor to assigned bottle
// - Then reverse pump for pre-sample purge
// - Then pump forward until liquid sensed
// - Measure volume from liquid detect until delivered
// - Reverse for post purge, then pump off
// - Restart interval or pulse total, wait again
// - Stop when bottles, count, or float (composite only); show finished
// - Start key begins the stored routine
// - Line length whole feet, 3 to 99
module sample_cycle_sequencer
   import sampler_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input wire logic mclk, // System clock, 50 MHz
   input wire logic rst_n, // Asynchronous reset
   input wire logic startKey, // Start-sampling key, level
   input wire logic paceFlow, // 1 flow pacing, 0 time pacing
   input wire logic composite, // 1 composite, 0 sequential
   input wire logic [23:0] intervalTicks, // Time pacing interval
   input wire logic [15:0] pulseTarget, // Flow pulses per sample
   input wire logic flowPulse, // Flow meter pulse, level
   input wire logic [7:0] bottleCount, // Bottles in the tub
   input wire logic [7:0] sampleTarget, // Composite sample count
   input wire logic [23:0] volumeTicks, // Delivery time after liquid
   input wire logic [6:0] lineFeet, // Intake line length, feet
   input wire logic liquidSense, // Liquid detector
   input wire logic floatStop, // Float shut-off
   input wire logic distReady, // Distributor arrived
   output logic distGo, // Distributor move request, pulse
   output logic [4:0] distBottle, // Target bottle index
   output logic pumpFwd, // Pump forward
   output logic pumpRev, // Pump reverse
   output logic running, // Routine active
   output logic done, // Routine finished
   output logic lineFeetBad // Start refused, bad line length
);

   seq_state_t state;
   seq_state_t next_state;
   logic [31:0] tickDiv;
   logic tickEn;
   logic [23:0] cnt;
   logic [15:0] flowCount;
   logic [7:0] eventCount;
   logic [6:0] feetHeld;
   logic startPrev;
   logic flowPrev;

   ////////////////////////////////////////////////////////////////////////
   // Time base
   assign tickEn = (tickDiv == 32'(TICK_DIV - 1));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tickDiv <= 32'h00000000;
      end else if (tickEn) begin
         tickDiv <= 32'h00000000;
      end else begin
         tickDiv <= tickDiv + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase end compare: counts the tick now arriving, so a limit of N ends on the Nth tick
   function automatic logic tickReached(input logic [23:0] count, input logic [23:0] limit);
      tickReached = (count + 24'h000001) >= limit;
   endfunction

   // Decoding of events
   wire startEdge = startKey && !startPrev;
   wire flowEdge = flowPulse && !flowPrev;
   wire lineOk = (lineFeet >= LINE_FEET_MIN) && (lineFeet <= LINE_FEET_MAX);
   wire startOk = startEdge && lineOk;
   wire timeHit = !paceFlow && tickEn && tickReached(cnt, intervalTicks);
   wire flowHit = paceFlow && flowEdge && ((flowCount + 16'h0001) == pulseTarget);
   wire trigger = timeHit || flowHit;
   wire floatHalt = composite && floatStop;
   wire purgeDone = tickEn && tickReached(cnt, purgeLen(feetHeld));
   wire settleDone = tickEn && tickReached(cnt, PUMP_SETTLE_TICKS);
   wire volumeDone = tickEn && tickReached(cnt, volumeTicks);
   wire [7:0] eventLimit = composite ? sampleTarget : bottleCount;
   wire lastEvent = (eventCount + 8'h01) >= eventLimit;

   // Pump direction straight from state, so a settle state always sits between reversals
   assign pumpRev = (state == ST_PRE_PURGE) || (state == ST_POST_PURGE);
   assign pumpFwd = (state == ST_FILL) || (state == ST_DELIVER);
   assign running = (state != ST_IDLE) && (state != ST_FINISH);
   assign done = (state == ST_FINISH);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE, ST_FINISH: begin
            if (startOk) next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (floatHalt) next_state = ST_FINISH;
            else if (trigger) next_state = ST_MOVE;
         end
         ST_MOVE: begin
            if (distReady) next_state = ST_PRE_PURGE;
         end
         ST_PRE_PURGE: begin
            if (purgeDone) next_state = ST_SETTLE_A;
         end
         ST_SETTLE_A: begin
            if (settleDone) next_state = ST_FILL;
         end
         ST_FILL: begin
            if (liquidSense) next_state = ST_DELIVER;
         end
         ST_DELIVER: begin
            if (volumeDone) next_state = ST_SETTLE_B;
         end
         ST_SETTLE_B: begin
            if (settleDone) next_state = ST_POST_PURGE;
         end
         ST_POST_PURGE: begin
            if (purgeDone) next_state = (lastEvent || floatHalt) ? ST_FINISH : ST_WAIT;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // State, edge history and the interval counter, cleared on every state change
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         startPrev <= 1'b0;
         flowPrev <= 1'b0;
         cnt <= CNT_RESET;
      end else begin
         state <= next_state;
         startPrev <= startKey;
         flowPrev <= flowPulse;
         if (next_state != state) cnt <= CNT_RESET;
         else if (tickEn) cnt <= cnt + 24'h000001;
      end
   end

   // Flow pulses count only while waiting; pulses during an event are dropped
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flowCount <= FLOW_RESET;
      end else if (state != ST_WAIT || next_state != ST_WAIT) begin
         flowCount <= FLOW_RESET;
      end else if (flowEdge) begin
         flowCount <= flowCount + 16'h0001;
      end
   end

   // Event count, bottle selection and the line length captured at start
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         eventCount <= EVENT_RESET;
         distBottle <= BOTTLE_RESET;
         feetHeld <= LINE_FEET_MIN;
         distGo <= 1'b0;
         lineFeetBad <= 1'b0;
      end else begin
         distGo <= (state == ST_WAIT) && (next_state == ST_MOVE);
         if (startEdge && (state == ST_IDLE || state == ST_FINISH)) begin
            lineFeetBad <= !lineOk;
         end
         if (startOk && (state == ST_IDLE || state == ST_FINISH)) begin
            eventCount <= EVENT_RESET;
            distBottle <= BOTTLE_RESET;
            feetHeld <= lineFeet;
         end else if (state == ST_POST_PURGE && purgeDone) begin
            eventCount <= eventCount + 8'h01;
            // Composite stays on the single container
            if (!composite) distBottle <= distBottle + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_trigger_moves;
      @(posedge mclk) disable iff (!rst_n) (state == ST_WAIT && !floatHalt && trigger) |=> (state == ST_MOVE) ##1 (state == ST_MOVE || state == ST_PRE_PURGE);
   endproperty
   a_trigger_moves: assert property (p_trigger_moves) else $error("trigger did not start an event");

   property p_time_pace;
      @(posedge mclk) disable iff (!rst_n) (state == ST_WAIT && !paceFlow && !floatHalt && tickEn && cnt + 24'h000001 >= intervalTicks) |=> distGo;
   endproperty
   a_time_pace: assert property (p_time_pace) else $error("interval expiry missed");

   property p_flow_pace;
      @(posedge mclk) disable iff (!rst_n) (state == ST_WAIT && paceFlow && !floatHalt && flowEdge && flowCount == pulseTarget - 16'h0001) |=> distGo && state == ST_MOVE;
   endproperty
   a_flow_pace: assert property (p_flow_pace) else $error("pulse total match missed");

   property p_move_first;
      @(posedge mclk) disable iff (!rst_n) distGo |-> $past(state) == ST_WAIT && state == ST_MOVE;
   endproperty
   a_move_first: assert property (p_move_first) else $error("distributor request outside event start");

   property p_pre_purge;
      @(posedge mclk) disable iff (!rst_n) (state == ST_MOVE && distReady) |=> pumpRev && !pumpFwd;
   endproperty
   a_pre_purge: assert property (p_pre_purge) else $error("no reverse purge after move");

   property p_fill_fwd;
      @(posedge mclk) disable iff (!rst_n) (state == ST_FILL && !liquidSense) |=> pumpFwd;
   endproperty
   a_fill_fwd: assert property (p_fill_fwd) else $error("pump stopped before liquid");

   property p_measure;
      @(posedge mclk) disable iff (!rst_n) $rose(state == ST_DELIVER) |-> $past(liquidSense) && cnt == CNT_RESET;
   endproperty
   a_measure: assert property (p_measure) else $error("volume started without liquid");

   property p_post_off;
      @(posedge mclk) disable iff (!rst_n) (state == ST_POST_PURGE && purgeDone) |=> !pumpFwd && !pumpRev;
   endproperty
   a_post_off: assert property (p_post_off) else $error("pump left on after post purge");

   property p_restart;
      @(posedge mclk) disable iff (!rst_n) $rose(state == ST_WAIT) |-> cnt == CNT_RESET && flowCount == FLOW_RESET;
   endproperty
   a_restart: assert property (p_restart) else $error("pacing not restarted");

   property p_finish;
      @(posedge mclk) disable iff (!rst_n) (state == ST_WAIT && floatHalt) |=> done && !pumpFwd && !pumpRev;
   endproperty
   a_finish: assert property (p_finish) else $error("float shut-off ignored");

   property p_start;
      @(posedge mclk) disable iff (!rst_n) (state == ST_IDLE && startEdge) |=> (state == ST_WAIT) == !lineFeetBad;
   endproperty
   a_start: assert property (p_start) else $error("start key handling wrong");

   property p_no_reverse_snap;
      @(posedge mclk) disable iff (!rst_n) (pumpFwd && $past(pumpRev)) || (pumpRev && $past(pumpFwd)) || (state == ST_MOVE && (pumpFwd || pumpRev)) |-> 1'b0;
   endproperty
   a_no_reverse_snap: assert property (p_no_reverse_snap) else $error("pump not stopped before reversal");
endmodule

// File: common/sampler_pkg.sv
package sampler_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

   // Pump timing, in ticks of the time base
   localparam logic [23:0] PUMP_SETTLE_TICKS = 24'h000064;
   localparam logic [23:0] PURGE_BASE_TICKS = 24'h0001F4;
   localparam logic [23:0] PURGE_PER_FOOT_TICKS = 24'h0000C8;

   // Intake line length limits, whole feet
   localparam logic [6:0] LINE_FEET_MIN = 7'h03;
   localparam logic [6:0] LINE_FEET_MAX = 7'h63;

   // Value of counters after reset
   localparam logic [23:0] CNT_RESET = 24'h000000;
   localparam logic [15:0] FLOW_RESET = 16'h0000;
   localparam logic [7:0] EVENT_RESET = 8'h00;
   localparam logic [4:0] BOTTLE_RESET = 5'h00;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_WAIT = 4'b0001,
      ST_MOVE = 4'b0010,
      ST_PRE_PURGE = 4'b0011,
      ST_SETTLE_A = 4'b0100,
      ST_FILL = 4'b0101,
      ST_DELIVER = 4'b0110,
      ST_SETTLE_B = 4'b0111,
      ST_POST_PURGE = 4'b1000,
      ST_FINISH = 4'b1001
   } seq_state_t;

   // Purge length grows with the intake line so the whole line is cleared
   function automatic logic [23:0] purgeLen(input logic [6:0] feet);
      purgeLen = PURGE_BASE_TICKS + PURGE_PER_FOOT_TICKS * {17'h00000, feet};
   endfunction
endpackage

// File: bench/flow_meter_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Flow meter stand-in, quiet low between pulses
module flow_meter_model #(
   parameter int HIGH_CYCLES = 3 // Pulse width in clocks
) (
   input wire logic mclk, // Sampler clock
   output logic flowPulse // Pulse toward the sampler
);
   initial begin
      flowPulse = 1'b0;
   end
   // Same width per pulse so each stands for equal flow; gap sets pace
   task automatic send(input int n, input int gap);
      repeat (n) begin
         @(posedge mclk);
         flowPulse <= 1'b1;
         repeat (HIGH_CYCLES) @(posedge mclk);
         flowPulse <= 1'b0;
         repeat (gap) @(posedge mclk);
      end
   endtask
endmodule

// File: bench/sample_cycle_sequencer_tb.sv
`timescale 1ns/1ps
module sample_cycle_sequencer_tb;
   import sampler_pkg::*;
   localparam int DIV = 4;
   localparam int PURGE = (int'(PURGE_BASE_TICKS) + int'(PURGE_PER_FOOT_TICKS) * 3) * DIV;
   localparam int SETTLE = int'(PUMP_SETTLE_TICKS) * DIV;
   localparam int VOL = 10 * DIV;
   logic mclk = 1'b0, rst_n = 1'b0, startKey = 1'b0, paceFlow = 1'b0, composite = 1'b0;
   logic liquidSense = 1'b0, floatStop = 1'b0, distReady = 1'b0;
   logic [23:0] intervalTicks = 24'h000005, volumeTicks = 24'h00000A;
   logic [15:0] pulseTarget = 16'h0003;
   logic [7:0] bottleCount = 8'h02, sampleTarget = 8'h01;
   logic [6:0] lineFeet = 7'h02;
   logic flowPulse, distGo, pumpFwd, pumpRev, running, done, lineFeetBad;
   logic [4:0] distBottle;
   wire logic [4:0] obs = {done, distGo, pumpRev, pumpFwd, running};
   int num_errors = 0, checked = 0, waited = 0, goCount = 0;
   ////////////////////////////////////////////////////////////
   // Clock, and a tally so a one-cycle move pulse is never missed
   always #10 mclk = ~mclk;
   always @(posedge mclk) if (distGo === 1'b1) goCount <= goCount + 1;
   sample_cycle_sequencer #(.TICK_DIV(DIV)) dut_u (.mclk(mclk), .rst_n(rst_n), .startKey(startKey),
      .paceFlow(paceFlow), .composite(composite), .intervalTicks(intervalTicks), .pulseTarget(pulseTarget),
      .flowPulse(flowPulse), .bottleCount(bottleCount), .sampleTarget(sampleTarget),
      .volumeTicks(volumeTicks), .lineFeet(lineFeet), .liquidSense(liquidSense), .floatStop(floatStop),
      .distReady(distReady), .distGo(distGo), .distBottle(distBottle), .pumpFwd(pumpFwd),
      .pumpRev(pumpRev), .running(running), .done(done), .lineFeetBad(lineFeetBad));
   flow_meter_model meter_u (.mclk(mclk), .flowPulse(flowPulse));
   ////////////////////////////////////////////////////////////
   // Compare helpers
   task automatic fail(input string msg);
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
   endtask
   task automatic checkBit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) fail(what);
   endtask
   task automatic checkSpan(input int got, input int lo, input int hi, input string what);
      checked++;
      if (got < lo || got > hi) fail(what);
   endtask
   // Bounded wait, sampled 1 ns after the edge so outputs have settled
   task automatic waitObs(input logic [4:0] mask, input logic [4:0] val, input int limit);
      waited = 0;
      do begin
         @(posedge mclk);
         #1;
         waited++;
      end while ((obs & mask) !== val && waited < limit);
      if ((obs & mask) !== val) fail("wait ran out");
   endtask
   task automatic pressStart();
      @(posedge mclk);
      startKey <= 1'b1;
      repeat (2) @(posedge mclk);
      startKey <= 1'b0;
      #1;
   endtask
   // One whole sample event; phase spans allow the partial first tick
   task automatic runEvent(input logic [4:0] bottle, input int lo, input int hi);
      waitObs(5'b01000, 5'b01000, 40);
      checkSpan(waited, lo, hi, "pacing delay");
      checkBit(distBottle === bottle, 1'b1, "bottle index");
      repeat (3) @(posedge mclk);
      #1;
      checkBit(pumpFwd | pumpRev, 1'b0, "pump on while moving");
      @(posedge mclk);
      distReady <= 1'b1;
      waitObs(5'b00110, 5'b00100, 10);
      @(posedge mclk);
      distReady <= 1'b0;
      waitObs(5'b00110, 5'b00000, PURGE + 8);
      checkSpan(waited, PURGE - DIV - 3, PURGE + 2, "pre purge");
      waitObs(5'b00110, 5'b00010, SETTLE + 8);
      checkSpan(waited, SETTLE - DIV - 2, SETTLE + 2, "stop before forward");
      repeat (40) @(posedge mclk);
      #1;
      checkBit(pumpFwd, 1'b1, "forward until liquid");
      @(posedge mclk);
      liquidSense <= 1'b1;
      waitObs(5'b00110, 5'b00000, VOL + 8);
      checkSpan(waited, VOL - DIV - 2, VOL + 2, "delivery");
      @(posedge mclk);
      liquidSense <= 1'b0;
      waitObs(5'b00110, 5'b00100, SETTLE + 8);
      waitObs(5'b00110, 5'b00000, PURGE + 8);
      checkSpan(waited, PURGE - DIV - 3, PURGE + 2, "post purge");
   endtask
   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic testLineFeet();
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk);
         lineFeet <= (i == 0) ? 7'h02 : 7'h64;
         pressStart();
         checkBit(lineFeetBad, 1'b1, "bad length taken");
         checkBit(running, 1'b0, "ran with bad length");
      end
      $display("test line length finished");
   endtask
   task automatic testTimeSeq();
      @(posedge mclk);
      lineFeet <= 7'h03;
      pressStart();
      checkBit(running, 1'b1, "start key");
      checkBit(lineFeetBad, 1'b0, "good length refused");
      runEvent(5'h00, 12, 24);
      checkBit(running, 1'b1, "not waiting again");
      runEvent(5'h01, 12, 24);
      waitObs(5'b10001, 5'b10000, 8);
      $display("test time sequential finished");
   endtask
   task automatic testFlow();
      int g;
      g = goCount;
      @(posedge mclk);
      paceFlow <= 1'b1;
      composite <= 1'b1;
      intervalTicks <= 24'h000002;
      pressStart();
      meter_u.send(2, 9);
      repeat (30) @(posedge mclk);
      checkSpan(goCount - g, 0, 0, "early flow trigger");
      fork
         meter_u.send(1, 2);
      join_none
      runEvent(5'h00, 1, 10);
      waitObs(5'b10001, 5'b10000, 8);
      $display("test flow composite finished");
   endtask
   task automatic testFloat();
      @(posedge mclk);
      paceFlow <= 1'b0;
      sampleTarget <= 8'h05;
      intervalTicks <= 24'h000100;
      // Longest legal line; the float stop ends the run before any long purge
      lineFeet <= 7'h63;
      pressStart();
      checkBit(running, 1'b1, "restart refused");
      checkBit(lineFeetBad, 1'b0, "top length refused");
      @(posedge mclk);
      floatStop <= 1'b1;
      waitObs(5'b10001, 5'b10000, 8);
      $display("test float stop finished");
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      testLineFeet();
      testTimeSeq();
      testFlow();
      testFloat();
      results();
   end
   // Run needs about 30000 clocks; cut a hang well past that
   initial begin
      repeat (60000) @(posedge mclk);
      num_errors++;
      results();
   end
endmodule
